// ===== src/apdr_pkg.sv
/*
 * Constants and carrier types for the analog power and PLL divider
 * register bank: register offsets, field positions, reset values and
 * the ramp timing count.
 * Assumes a 125 MHz system clock and 16-bit register words.
 */
package apdr_pkg;

    // ------------------------------------------------------------
    // bus geometry and offsets
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [15:0] OFS_POWER = 16'h0030;
    localparam logic [15:0] OFS_DIVIDER = 16'h0032;
    localparam logic [15:0] OFS_CLKTOP = 16'h0034;
    localparam logic [15:0] OFS_STATUS = 16'h0036;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POWER_W = 10;
    localparam int INT_LSB = 11;
    localparam int INT_W = 5;
    localparam int FRAC_W = 11;
    localparam int HALVE_BIT = 3;
    localparam int LOCK_BIT = 4;
    localparam int RAMP_BIT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [9:0] POWER_RST = 10'h060;
    localparam logic [4:0] INT_RST = 5'h0A;
    localparam logic [10:0] FRAC_RST = 11'h000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLOCK_HZ = 125000000;
    localparam longint RAMP_DOWN_MS = 400;
    localparam longint RAMP_DOWN_CYCLES = RAMP_DOWN_MS * CLOCK_HZ / 1000;
    localparam int RAMP_CNT_W = 26;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic coreRegulatorOn;
        logic oscAmplifierOn;
        logic groundRefBufferOn;
        logic inputStereo;
        logic biasCurrentOn;
        logic headphoneOn;
        logic outputConvOn;
        logic caplessHeadphoneOn;
        logic inputConvOn;
        logic lineoutOn;
    } apdr_power_t;

    typedef struct packed {
        logic [4:0] intPart;
        logic [10:0] pllFractionPart;
    } apdr_divider_t;

endpackage

// ===== src/apdr_regs.sv
/*
 * Register bank for the lower analog power word, the PLL divider word,
 * the reference pre-divide control and the analog status word.
 * Assumes a single 125 MHz clock, a synchronous active-high reset, a
 * plain strobe register port, and a lock level from the analog PLL
 * that is asynchronous to the clock.
 */
`timescale 1ns/100ps

module apdr_regs #(
    parameter longint RAMP_CYCLES = apdr_pkg::RAMP_DOWN_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWriteData,
    input wire logic regWriteStrobe,
    input wire logic regReadStrobe,
    output logic [15:0] regReadData,
    input wire logic pllPowerUp,
    input wire logic pllLockRaw,
    output apdr_pkg::apdr_power_t powerCtrl,
    output apdr_pkg::apdr_divider_t pllDivider,
    output logic refClockHalve,
    output logic inputMonoLeft,
    output logic rampDownBusy
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic hitPower;
    logic hitDivider;
    logic hitClkTop;
    logic hitStatus;

    assign hitPower = regAddr == apdr_pkg::OFS_POWER;
    assign hitDivider = regAddr == apdr_pkg::OFS_DIVIDER;
    assign hitClkTop = regAddr == apdr_pkg::OFS_CLKTOP;
    assign hitStatus = regAddr == apdr_pkg::OFS_STATUS;

    // ------------------------------------------------------------
    // analog power word
    // ------------------------------------------------------------
    apdr_pkg::apdr_power_t power_r;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            power_r <= apdr_pkg::apdr_power_t'(apdr_pkg::POWER_RST);
        end
        else if (regWriteStrobe && hitPower)
        begin
            // every enable lands as written, no sequencing applied
            power_r <= apdr_pkg::apdr_power_t'(
                regWriteData[apdr_pkg::POWER_W-1:0]);
        end
    end

    // enables leave straight from the flops
    assign powerCtrl = power_r;

    // ------------------------------------------------------------
    // input converter channel mode
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            inputMonoLeft <= 1'b0;
        end
        else
        begin
            // mode only means something while the converter is powered
            inputMonoLeft <= power_r.inputConvOn
                && !power_r.inputStereo;
        end
    end

    // ------------------------------------------------------------
    // ground reference ramp-down tracking
    // ------------------------------------------------------------
    logic [apdr_pkg::RAMP_CNT_W-1:0] rampCnt_r;
    logic gndPrev_r;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            gndPrev_r <= 1'b0;
        end
        else
        begin
            gndPrev_r <= power_r.groundRefBufferOn;
        end
    end

    // the buffer stays down while this counts; software watches busy
    // before it drops the headphone and lineout enables
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            rampCnt_r <= '0;
        end
        else if (power_r.groundRefBufferOn && !gndPrev_r)
        begin
            rampCnt_r <= '0;
        end
        else if (!power_r.groundRefBufferOn && gndPrev_r)
        begin
            rampCnt_r <= apdr_pkg::RAMP_CNT_W'(RAMP_CYCLES);
        end
        else if (rampCnt_r != '0)
        begin
            rampCnt_r <= rampCnt_r - 1'b1;
        end
    end

    assign rampDownBusy = rampCnt_r != '0;

    // ------------------------------------------------------------
    // PLL divider word
    // ------------------------------------------------------------
    apdr_pkg::apdr_divider_t divider_r;
    logic divWriteOk;

    // writes while the PLL runs are dropped so the loop never sees a
    // divisor change mid-lock
    assign divWriteOk = regWriteStrobe && hitDivider
        && !pllPowerUp;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            divider_r.intPart <= apdr_pkg::INT_RST;
            divider_r.pllFractionPart <= apdr_pkg::FRAC_RST;
        end
        else if (divWriteOk)
        begin
            divider_r.intPart <= regWriteData[
                apdr_pkg::INT_LSB+apdr_pkg::INT_W-1:apdr_pkg::INT_LSB];
            divider_r.pllFractionPart <=
                regWriteData[apdr_pkg::FRAC_W-1:0];
        end
    end

    // ratio seen by the PLL is intPart + pllFractionPart / 2048
    assign pllDivider = divider_r;

    // ------------------------------------------------------------
    // reference pre-divide
    // ------------------------------------------------------------
    logic halve_r;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            halve_r <= 1'b0;
        end
        else if (regWriteStrobe && hitClkTop)
        begin
            halve_r <= regWriteData[apdr_pkg::HALVE_BIT];
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            refClockHalve <= 1'b0;
        end
        else
        begin
            // gated so a stale setting cannot reach a sleeping PLL
            refClockHalve <= halve_r && pllPowerUp;
        end
    end

    // ------------------------------------------------------------
    // lock synchroniser
    // ------------------------------------------------------------
    logic lockMeta_r;
    logic synthLockFlag;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            lockMeta_r <= 1'b0;
            synthLockFlag <= 1'b0;
        end
        else
        begin
            lockMeta_r <= pllLockRaw;
            synthLockFlag <= lockMeta_r;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [15:0] readMux;

    always_comb
    begin
        readMux = 16'h0000;
        if (hitPower)
        begin
            readMux[apdr_pkg::POWER_W-1:0] = power_r;
        end
        else if (hitDivider)
        begin
            readMux = divider_r;
        end
        else if (hitClkTop)
        begin
            readMux[apdr_pkg::HALVE_BIT] = halve_r;
        end
        else if (hitStatus)
        begin
            readMux[apdr_pkg::LOCK_BIT] = synthLockFlag;
            readMux[apdr_pkg::RAMP_BIT] = rampDownBusy;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            regReadData <= 16'h0000;
        end
        else if (regReadStrobe)
        begin
            regReadData <= readMux;
        end
        else
        begin
            // data stand for one cycle only
            regReadData <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_powerWrite;
        regWriteStrobe && hitPower;
    endsequence

    sequence s_lockHeld;
        pllLockRaw ##1 pllLockRaw;
    endsequence

    property p_powerWord;
        s_powerWrite |=> powerCtrl == $past(regWriteData[9:0]);
    endproperty
    a_powerWord: assert property (p_powerWord)
        else $error("power word not stored as written");

    property p_regulator;
        s_powerWrite |=> powerCtrl.coreRegulatorOn == $past(regWriteData[9]);
    endproperty
    a_regulator: assert property (p_regulator)
        else $error("core regulator enable wrong");

    property p_headphone;
        s_powerWrite ##1 !(regWriteStrobe && hitPower) |=>
            powerCtrl.headphoneOn == $past(regWriteData[4], 2)
            && $stable(powerCtrl);
    endproperty
    a_headphone: assert property (p_headphone)
        else $error("headphone enable wrong or not held");

    property p_resetValues;
        disable iff (1'b0)
        reset |=> powerCtrl.biasCurrentOn && powerCtrl.inputStereo
            && pllDivider.intPart == 5'h0A
            && pllDivider.pllFractionPart == 11'h000;
    endproperty
    a_resetValues: assert property (p_resetValues)
        else $error("reset values wrong");

    property p_monoMode;
        s_powerWrite |=> ##1 inputMonoLeft == ($past(regWriteData[1], 2)
            && !$past(regWriteData[6], 2));
    endproperty
    a_monoMode: assert property (p_monoMode)
        else $error("mono select wrong");

    property p_divFrozen;
        pllPowerUp && regWriteStrobe && hitDivider |=> $stable(pllDivider);
    endproperty
    a_divFrozen: assert property (p_divFrozen)
        else $error("divider changed while PLL up");

    property p_divWrite;
        divWriteOk |=> pllDivider.pllFractionPart == $past(regWriteData[10:0])
            && pllDivider.intPart == $past(regWriteData[15:11]);
    endproperty
    a_divWrite: assert property (p_divWrite)
        else $error("divider write lost");

    property p_halve;
        ##1 refClockHalve == $past(halve_r && pllPowerUp);
    endproperty
    a_halve: assert property (p_halve)
        else $error("reference halving wrong");

    property p_lock;
        s_lockHeld |-> ##1 synthLockFlag;
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock flag late");

    property p_rampStart;
        $fell(powerCtrl.groundRefBufferOn) |-> ##[1:2] rampDownBusy;
    endproperty
    a_rampStart: assert property (p_rampStart)
        else $error("ramp-down not started");

endmodule // apdr_regs

// ===== sim/apdr_tb.sv
/*
 * Self-checking bench for the analog power and PLL divider register bank.
 * Assumes the design's register port answers reads one cycle after the
 * strobe and that the ramp count is shortened through RAMP_CYCLES.
 */
`timescale 1ns/100ps

module testbench;

    localparam int RAMP_SIM = 20;

    logic clock;
    logic reset;
    logic [15:0] regAddr;
    logic [15:0] regWriteData;
    logic regWriteStrobe;
    logic regReadStrobe;
    logic [15:0] regReadData;
    logic pllPowerUp;
    logic pllLockRaw;
    apdr_pkg::apdr_power_t powerCtrl;
    apdr_pkg::apdr_divider_t pllDivider;
    logic refClockHalve;
    logic inputMonoLeft;
    logic rampDownBusy;
    int badCount;
    int comparisons;
    int n;

    apdr_regs #(
        .RAMP_CYCLES(RAMP_SIM)
    ) DUT (
        .clock(clock),
        .reset(reset),
        .regAddr(regAddr),
        .regWriteData(regWriteData),
        .regWriteStrobe(regWriteStrobe),
        .regReadStrobe(regReadStrobe),
        .regReadData(regReadData),
        .pllPowerUp(pllPowerUp),
        .pllLockRaw(pllLockRaw),
        .powerCtrl(powerCtrl),
        .pllDivider(pllDivider),
        .refClockHalve(refClockHalve),
        .inputMonoLeft(inputMonoLeft),
        .rampDownBusy(rampDownBusy)
    );

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            badCount++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWriteData <= d;
        regWriteStrobe <= 1'b1;
        @(posedge clock);
        regWriteStrobe <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clock);
        regAddr <= a;
        regReadStrobe <= 1'b1;
        @(posedge clock);
        regReadStrobe <= 1'b0;
        #1;
        chk($sformatf("read %h", a), exp, regReadData);
        // the answer must not linger past its one cycle
        @(posedge clock);
        #1;
        chk("read idle", 16'h0000, regReadData);
    endtask

    // two edges cover the one-cycle lag of the derived outputs
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", badCount, comparisons);
        if (badCount == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clock);
        badCount++;
        stop_test();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        badCount = 0;
        comparisons = 0;
        reset = 1'b1;
        regAddr = 16'h0000;
        regWriteData = 16'h0000;
        regWriteStrobe = 1'b0;
        regReadStrobe = 1'b0;
        pllPowerUp = 1'b0;
        pllLockRaw = 1'b0;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        #1;
        chk("powerCtrl rst", 16'h0060, 16'(powerCtrl));
        chk("busy rst", 16'h0000, 16'(rampDownBusy));
        rd(16'h0030, 16'h0060);
        rd(16'h0032, {5'h0A, 11'h000});
        chk("divider rst", 16'h5000, pllDivider);
        rd(16'h0036, 16'h0000);
        // each power bit alone drives only its own enable
        for (int i = 0; i < 10; i++)
        begin
            wr(16'h0030, 16'h0001 << i);
            settle();
            chk("powerCtrl", 16'h0001 << i, 16'(powerCtrl));
            rd(16'h0030, 16'h0001 << i);
        end
        wr(16'h0030, 16'hFFFF);
        rd(16'h0030, 16'h03FF);
        chk("mono stereo", 16'h0000, 16'(inputMonoLeft));
        wr(16'h0030, 16'h0002);
        settle();
        chk("mono left", 16'h0001, 16'(inputMonoLeft));
        wr(16'h0030, 16'h0000);
        settle();
        chk("mono off", 16'h0000, 16'(inputMonoLeft));
        // ramp: lineout and headphone stay on across the clear
        wr(16'h0030, 16'h0091);
        wr(16'h0030, 16'h0011);
        @(posedge clock);
        #1;
        chk("busy start", 16'h0001, 16'(rampDownBusy));
        n = 1;
        while (rampDownBusy === 1'b1 && n < 100)
        begin
            @(posedge clock);
            #1;
            if (rampDownBusy === 1'b1)
                n++;
        end
        chk("busy length", 16'(RAMP_SIM), 16'(n));
        wr(16'h0030, 16'h0091);
        wr(16'h0030, 16'h0011);
        rd(16'h0036, 16'h0001);
        wr(16'h0030, 16'h0091);
        settle();
        chk("busy cut", 16'h0000, 16'(rampDownBusy));
        // 12 MHz master clock, 44.1 kHz family: 15 + 108/2048
        wr(16'h0032, {5'h0F, 11'h06C});
        rd(16'h0032, {5'h0F, 11'h06C});
        chk("divider", {5'h0F, 11'h06C}, pllDivider);
        @(posedge clock);
        pllPowerUp <= 1'b1;
        wr(16'h0032, 16'h1234);
        rd(16'h0032, {5'h0F, 11'h06C});
        chk("divider held", {5'h0F, 11'h06C}, pllDivider);
        wr(16'h0034, 16'h0008);
        settle();
        chk("halve on", 16'h0001, 16'(refClockHalve));
        rd(16'h0034, 16'h0008);
        @(posedge clock);
        pllPowerUp <= 1'b0;
        settle();
        chk("halve gated", 16'h0000, 16'(refClockHalve));
        // lock flag follows the raw level through two flops
        @(posedge clock);
        pllLockRaw <= 1'b1;
        repeat (3) @(posedge clock);
        rd(16'h0036, 16'h0010);
        @(posedge clock);
        pllLockRaw <= 1'b0;
        repeat (3) @(posedge clock);
        rd(16'h0036, 16'h0000);
        wr(16'h0036, 16'hFFFF);
        rd(16'h0036, 16'h0000);
        wr(16'h0040, 16'hFFFF);
        rd(16'h0040, 16'h0000);
        rd(16'h0030, 16'h0091);
        // a reset in mid-run brings every register back to its default
        @(posedge clock);
        reset <= 1'b1;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        #1;
        chk("powerCtrl rerst", 16'h0060, 16'(powerCtrl));
        chk("divider rerst", 16'h5000, pllDivider);
        chk("busy rerst", 16'h0000, 16'(rampDownBusy));
        rd(16'h0034, 16'h0000);
        rd(16'h0030, 16'h0060);
        stop_test();
    end

endmodule // testbench
